// ### src/cdmu_device.sv
// Display address, raster mode and transparent update logic of the controller.
// Function
// R1: Fetch addresses generated continuously for refresh.
// R2: Outside logic arbitrates shared memory accesses.
// R3: Transparent mode: device alone drives addresses.
// R4: Host priority: mux switches on request.
// R5: Interleave: device at phase low, host high.
// R6: Status bit 5 shows vertical blanking.
// R7: Interleaved transparent: pointer out each phase two.
// R8: Blanking transparent: pointer out only in blanking.
// R9: Outside latch holds data until retrace.
// R10: Non-interlaced scans every line each field.
// R11: Interlace sync delays vsync half line.
// R12: Sync-video: even/odd lines per field.
// R13: Host programs odd horizontal total.
// R14: Host halves vertical registers in sync-video.
// R15: Mode bits four, five skew enable, cursor.
// R16: Top raster bit is update strobe.
// R17: Update pointer increments after each update.
// R18: Dummy location access requests an update.
// R19: Cursor skew delays one character clock.
// R20: No strobe in blanking without pending update.
`timescale 1ns/1ps
module cdmu_device (
  input  wire logic  mclk,
  input  wire logic  reset,
  cdmu_if.device     lnk,
  output logic [6:0] row_count,
  output logic       field_odd
);
  // ------------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------------
  logic [4:0]  sel_q, sel_d;
  logic [7:0]  h_total_q, h_total_d, h_disp_q, h_disp_d, mode_q, mode_d, rdata_q, rdata_d;
  logic [6:0]  v_total_q, v_total_d, v_disp_q, v_disp_d, v_sync_q, v_sync_d;
  logic [4:0]  scan_q, scan_d;
  logic [13:0] start_q, start_d, curs_q, curs_d, upd_q, upd_d;
  logic        pend_q, pend_d, ready_q, ready_d;
  // Raster state.
  logic [7:0]  h_cnt_q, h_cnt_d;
  logic [4:0]  line_q, line_d;
  logic [6:0]  row_q, row_d;
  logic [13:0] row_base_q, row_base_d, addr_q, addr_d;
  logic        odd_q, odd_d, vs_q, vs_d, de_q, de_d, de_dly_q, cur_q, cur_d, cur_dly_q;
  logic        stb_q, stb_d, phi_prev_q;
  logic [3:0]  vs_cnt_q, vs_cnt_d;
  logic [13:0] ma;
  logic        wr_reg, acc_dummy, hblank, vblank, line_end, row_end, field_end;
  logic        transp, interlaced, sync_vid, do_update;
  logic [4:0]  line_first, line_step;
  logic [7:0]  vs_point;

  assign wr_reg     = lnk.bus_cs && lnk.bus_we && lnk.bus_rs;
  assign acc_dummy  = lnk.bus_cs && lnk.bus_rs && (sel_q == cdmu_pkg::REG_DUMMY);
  assign transp     = mode_q[cdmu_pkg::MODE_TRANSP];
  assign interlaced = mode_q[cdmu_pkg::MODE_IL_LO];
  assign sync_vid   = mode_q[cdmu_pkg::MODE_IL_LO +: 2] == cdmu_pkg::IL_SYNC_VID;

  // Host writes land in the selected register; reads give status or pointer.
  always_comb begin
    sel_d     = sel_q;
    h_total_d = h_total_q;
    h_disp_d  = h_disp_q;
    v_total_d = v_total_q;
    v_disp_d  = v_disp_q;
    v_sync_d  = v_sync_q;
    mode_d    = mode_q;
    scan_d    = scan_q;
    start_d   = start_q;
    curs_d    = curs_q;
    rdata_d   = 8'h00;
    if (lnk.bus_cs && lnk.bus_we && !lnk.bus_rs) begin
      sel_d = lnk.bus_wdata[4:0];
    end
    if (wr_reg) begin
      case (sel_q)
        cdmu_pkg::REG_H_TOTAL:  h_total_d = lnk.bus_wdata;
        cdmu_pkg::REG_H_DISP:   h_disp_d  = lnk.bus_wdata;
        cdmu_pkg::REG_V_TOTAL:  v_total_d = lnk.bus_wdata[6:0];
        cdmu_pkg::REG_V_DISP:   v_disp_d  = lnk.bus_wdata[6:0];
        cdmu_pkg::REG_V_SYNC:   v_sync_d  = lnk.bus_wdata[6:0];
        cdmu_pkg::REG_MODE:     mode_d    = lnk.bus_wdata;
        cdmu_pkg::REG_SCAN:     scan_d    = lnk.bus_wdata[4:0];
        cdmu_pkg::REG_START_HI: start_d[13:8] = lnk.bus_wdata[5:0];
        cdmu_pkg::REG_START_LO: start_d[7:0]  = lnk.bus_wdata;
        cdmu_pkg::REG_CURS_HI:  curs_d[13:8]  = lnk.bus_wdata[5:0];
        cdmu_pkg::REG_CURS_LO:  curs_d[7:0]   = lnk.bus_wdata;
        default: ;
      endcase
    end
    if (lnk.bus_cs && !lnk.bus_we) begin
      if (!lnk.bus_rs) begin
        rdata_d[cdmu_pkg::STAT_VBLANK]    = vblank;  // [R6]
        rdata_d[cdmu_pkg::STAT_UPD_READY] = ready_q;
      end else if (sel_q == cdmu_pkg::REG_UPD_HI) begin
        rdata_d = {2'h0, upd_q[13:8]};
      end else if (sel_q == cdmu_pkg::REG_UPD_LO) begin
        rdata_d = upd_q[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Transparent update pointer
  // ------------------------------------------------------------------
  // The update happens when the phase-two window closes in interleave mode, or in
  // one blanking cycle in blanking mode; a new request in that cycle is kept.
  assign do_update = transp && pend_q && (mode_q[cdmu_pkg::MODE_BLANK_UPD] ?
                     (hblank || vblank) : (phi_prev_q && !lnk.phi2));
  always_comb begin
    upd_d   = upd_q;
    pend_d  = pend_q;
    ready_d = ready_q;
    stb_d   = 1'b0;
    if (do_update) begin
      upd_d   = upd_q + 14'h0001;  // [R17]
      pend_d  = 1'b0;
      ready_d = 1'b1;
    end
    if (wr_reg && sel_q == cdmu_pkg::REG_UPD_HI) begin
      upd_d[13:8] = lnk.bus_wdata[5:0];
    end
    if (wr_reg && sel_q == cdmu_pkg::REG_UPD_LO) begin
      upd_d[7:0] = lnk.bus_wdata;
    end
    if (acc_dummy) begin
      pend_d  = 1'b1;  // [R18]
      ready_d = 1'b0;
    end
    if (transp && mode_q[cdmu_pkg::MODE_BLANK_UPD]) begin
      stb_d = pend_q && (hblank || vblank);  // [R8] [R20]
    end else if (transp) begin
      stb_d = lnk.phi2;  // [R7]
    end
  end

  // ------------------------------------------------------------------
  // Raster counters
  // ------------------------------------------------------------------
  assign hblank     = h_cnt_q >= h_disp_q;
  assign vblank     = row_q >= v_disp_q;
  assign line_end   = h_cnt_q == h_total_q;
  assign line_first = sync_vid ? {4'h0, odd_q} : 5'h00;  // [R12]
  assign line_step  = sync_vid ? 5'h02 : 5'h01;          // [R10] [R12]
  assign row_end    = line_end && ((line_q + line_step) > scan_q);
  assign field_end  = row_end && (row_q == v_total_q);
  assign ma         = row_base_q + {6'h00, h_cnt_q};     // [R1]
  // Odd fields in either interlace mode start vsync half a line late.
  assign vs_point   = (interlaced && odd_q) ? {1'b0, h_total_q[7:1]} + 8'h01 : 8'h00;

  always_comb begin
    h_cnt_d    = line_end ? 8'h00 : h_cnt_q + 8'h01;
    line_d     = line_q;
    row_d      = row_q;
    row_base_d = row_base_q;
    odd_d      = odd_q;
    vs_d       = vs_q;
    vs_cnt_d   = vs_cnt_q;
    if (line_end) begin
      line_d = line_q + line_step;
    end
    if (row_end) begin
      line_d     = line_first;
      row_d      = row_q + 7'h01;
      row_base_d = row_base_q + {6'h00, h_disp_q};
    end
    if (field_end) begin
      row_d      = 7'h00;
      row_base_d = start_q;
      odd_d      = interlaced ? !odd_q : 1'b0;
      line_d     = (sync_vid && !odd_q) ? 5'h01 : 5'h00;
    end
    // Vsync begins at the programmed row and lasts a fixed count of lines.
    if (h_cnt_q == vs_point) begin
      if (row_q == v_sync_q && line_q == line_first && !vs_q) begin
        vs_d     = 1'b1;  // [R11]
        vs_cnt_d = cdmu_pkg::VSYNC_LINES;
      end else if (vs_q) begin
        vs_cnt_d = vs_cnt_q - 4'h1;
        vs_d     = vs_cnt_q != 4'h1;
      end
    end
    de_d   = !hblank && !vblank;
    cur_d  = de_d && (ma == curs_q);
    addr_d = ma;
    if (stb_d) begin
      addr_d = upd_q;  // [R3] [R7] [R8]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sel_q      <= 5'h00;
      h_total_q  <= cdmu_pkg::RST_H_TOTAL;
      h_disp_q   <= cdmu_pkg::RST_H_DISP;
      v_total_q  <= cdmu_pkg::RST_V_TOTAL;
      v_disp_q   <= cdmu_pkg::RST_V_DISP;
      v_sync_q   <= cdmu_pkg::RST_V_SYNC;
      mode_q     <= 8'h00;
      scan_q     <= cdmu_pkg::RST_SCAN;
      start_q    <= 14'h0000;
      curs_q     <= 14'h0000;
      rdata_q    <= 8'h00;
      upd_q      <= 14'h0000;
      pend_q     <= 1'b0;
      ready_q    <= 1'b0;
      stb_q      <= 1'b0;
      phi_prev_q <= 1'b0;
      h_cnt_q    <= 8'h00;
      line_q     <= 5'h00;
      row_q      <= 7'h00;
      row_base_q <= 14'h0000;
      addr_q     <= 14'h0000;
      odd_q      <= 1'b0;
      vs_q       <= 1'b0;
      vs_cnt_q   <= 4'h0;
      de_q       <= 1'b0;
      de_dly_q   <= 1'b0;
      cur_q      <= 1'b0;
      cur_dly_q  <= 1'b0;
    end else begin
      sel_q      <= sel_d;
      h_total_q  <= h_total_d;
      h_disp_q   <= h_disp_d;
      v_total_q  <= v_total_d;
      v_disp_q   <= v_disp_d;
      v_sync_q   <= v_sync_d;
      mode_q     <= mode_d;
      scan_q     <= scan_d;
      start_q    <= start_d;
      curs_q     <= curs_d;
      rdata_q    <= rdata_d;
      upd_q      <= upd_d;
      pend_q     <= pend_d;
      ready_q    <= ready_d;
      stb_q      <= stb_d;
      phi_prev_q <= lnk.phi2;
      h_cnt_q    <= h_cnt_d;
      line_q     <= line_d;
      row_q      <= row_d;
      row_base_q <= row_base_d;
      addr_q     <= addr_d;
      odd_q      <= odd_d;
      vs_q       <= vs_d;
      vs_cnt_q   <= vs_cnt_d;
      de_q       <= de_d;
      de_dly_q   <= de_q;
      cur_q      <= cur_d;
      cur_dly_q  <= cur_q;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Skew costs one character of delay, which buys slow memories access time.
  assign lnk.disp_en     = mode_q[cdmu_pkg::MODE_DE_SKEW] ? de_dly_q : de_q;  // [R15]
  assign lnk.cursor      = mode_q[cdmu_pkg::MODE_CURS_SKEW] ? cur_dly_q : cur_q;  // [R15] [R19]
  assign lnk.raster_line = {transp ? stb_q : line_q[4], line_q[3:0]};  // [R16]
  assign lnk.disp_addr   = addr_q;
  assign lnk.bus_rdata   = rdata_q;
  assign lnk.vsync       = vs_q;
  assign row_count       = row_q;
  assign field_odd       = odd_q;
endmodule : cdmu_device

// ### shared/cdmu_pkg.sv
// Shared constants for the display memory update device and host ends.
package cdmu_pkg;
  // ------------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------------
  localparam logic [4:0] REG_H_TOTAL   = 5'h00;
  localparam logic [4:0] REG_H_DISP    = 5'h01;
  localparam logic [4:0] REG_V_TOTAL   = 5'h04;
  localparam logic [4:0] REG_V_DISP    = 5'h06;
  localparam logic [4:0] REG_V_SYNC    = 5'h07;
  localparam logic [4:0] REG_MODE      = 5'h08;
  localparam logic [4:0] REG_SCAN      = 5'h09;
  localparam logic [4:0] REG_START_HI  = 5'h0c;
  localparam logic [4:0] REG_START_LO  = 5'h0d;
  localparam logic [4:0] REG_CURS_HI   = 5'h0e;
  localparam logic [4:0] REG_CURS_LO   = 5'h0f;
  localparam logic [4:0] REG_UPD_HI    = 5'h12;
  localparam logic [4:0] REG_UPD_LO    = 5'h13;
  localparam logic [4:0] REG_DUMMY     = 5'h1f;
  // ------------------------------------------------------------------
  // Mode control fields and status bits
  // ------------------------------------------------------------------
  localparam int MODE_IL_LO      = 0;  // Interlace mode, two bits.
  localparam int MODE_TRANSP     = 3;  // Transparent addressing.
  localparam int MODE_DE_SKEW    = 4;
  localparam int MODE_CURS_SKEW  = 5;
  localparam int MODE_BLANK_UPD  = 7;  // Transparent update at blanking.
  localparam logic [1:0] IL_NONE      = 2'h0;
  localparam logic [1:0] IL_SYNC      = 2'h1;
  localparam logic [1:0] IL_SYNC_VID  = 2'h3;
  localparam int STAT_VBLANK     = 5;
  localparam int STAT_UPD_READY  = 7;
  // ------------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_H_TOTAL = 8'h1f;
  localparam logic [7:0] RST_H_DISP  = 8'h14;
  localparam logic [6:0] RST_V_TOTAL = 7'h0f;
  localparam logic [6:0] RST_V_DISP  = 7'h0c;
  localparam logic [6:0] RST_V_SYNC  = 7'h0d;
  localparam logic [4:0] RST_SCAN    = 5'h07;
  localparam logic [3:0] VSYNC_LINES = 4'h4;
  localparam logic [3:0] PHI_HALF    = 4'h3;  // Last count of each phase; a phase lasts one cycle more of the system clock.
  // Host access schemes.
  typedef enum logic [1:0] {CDMU_PRIO, CDMU_INTERLEAVE, CDMU_VBLANK} cdmu_scheme_t;
endpackage : cdmu_pkg

// ### shared/cdmu_if.sv
// Interface joining the display memory device and its host.
`timescale 1ns/1ps
interface cdmu_if;
  logic        bus_cs;
  logic        bus_rs;
  logic        bus_we;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic        phi2;
  logic [13:0] disp_addr;
  logic [4:0]  raster_line;
  logic        disp_en;
  logic        cursor;
  logic        vsync;
  modport device (input bus_cs, bus_rs, bus_we, bus_wdata, phi2,
                  output bus_rdata, disp_addr, raster_line, disp_en, cursor, vsync);
  modport host (output bus_cs, bus_rs, bus_we, bus_wdata, phi2,
                input bus_rdata, disp_addr, raster_line, disp_en, cursor, vsync);
endinterface : cdmu_if

// ### src/cdmu_host.sv
// Host end: register programming, shared-memory mux and transparent update latch.
`timescale 1ns/1ps
module cdmu_host (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  cdmu_if.host                       lnk,
  input  wire logic                  cfg_wr,
  input  wire logic [4:0]            cfg_index,
  input  wire logic [7:0]            cfg_value,
  input  wire cdmu_pkg::cdmu_scheme_t scheme,
  input  wire logic                  mem_req,
  input  wire logic [13:0]           mem_addr,
  input  wire logic [7:0]            mem_wdata,
  output logic                       busy,
  output logic                       mem_grant,
  output logic [13:0]                vram_addr,
  output logic [7:0]                 vram_wdata,
  output logic                       vram_we
);
  typedef enum {H_IDLE, H_SEL, H_DAT} cdmu_hst_t;
  cdmu_hst_t   st_q, st_d;
  logic [4:0]  idx_q [3];
  logic [7:0]  val_q [3];
  logic [4:0]  idx_d [3];
  logic [7:0]  val_d [3];
  logic [1:0]  n_q, n_d, k_q, k_d;
  logic [7:0]  mode_q, mode_d, latch_q, latch_d;
  logic [3:0]  ph_cnt_q, ph_cnt_d;
  logic        phi_q, phi_d, vb_q, vb_d;
  logic        transp, host_sel, sync_vid;

  assign transp   = mode_q[cdmu_pkg::MODE_TRANSP];
  assign sync_vid = mode_q[cdmu_pkg::MODE_IL_LO +: 2] == cdmu_pkg::IL_SYNC_VID;
  assign busy     = st_q != H_IDLE;

  // ------------------------------------------------------------------
  // Command sequencing
  // ------------------------------------------------------------------
  // Each write is an index cycle then a data cycle; idle cycles poll status.
  always_comb begin
    st_d    = st_q;
    n_d     = n_q;
    k_d     = k_q;
    mode_d  = mode_q;
    latch_d = latch_q;
    vb_d    = vb_q;
    idx_d   = idx_q;
    val_d   = val_q;
    if (st_q == H_IDLE && k_q == 2'h0) begin
      vb_d = lnk.bus_rdata[cdmu_pkg::STAT_VBLANK];
    end
    case (st_q)
      H_IDLE: begin
        if (cfg_wr) begin
          idx_d[0] = cfg_index;
          val_d[0] = cfg_value;
          n_d      = 2'h1;
          st_d     = H_SEL;
          if (cfg_index == cdmu_pkg::REG_MODE) begin
            mode_d = cfg_value;
          end
          if (cfg_index == cdmu_pkg::REG_H_TOTAL && mode_q[cdmu_pkg::MODE_IL_LO]) begin
            val_d[0] = cfg_value | 8'h01;  // [R13]
          end
          if (sync_vid && cfg_index == cdmu_pkg::REG_V_TOTAL) begin
            val_d[0] = {1'b0, cfg_value[7:1]} - 8'h01;  // [R14]
          end
          if (sync_vid && (cfg_index == cdmu_pkg::REG_V_DISP
                           || cfg_index == cdmu_pkg::REG_V_SYNC)) begin
            val_d[0] = {1'b0, cfg_value[7:1]};  // [R14]
          end
        end else if (mem_req && transp) begin
          latch_d  = mem_wdata;  // [R9]
          idx_d[0] = cdmu_pkg::REG_UPD_HI;
          val_d[0] = {2'h0, mem_addr[13:8]};
          idx_d[1] = cdmu_pkg::REG_UPD_LO;
          val_d[1] = mem_addr[7:0];
          idx_d[2] = cdmu_pkg::REG_DUMMY;
          val_d[2] = 8'h00;
          n_d      = 2'h3;
          st_d     = H_SEL;  // [R7]
        end
        k_d = 2'h0;
      end
      H_SEL: st_d = H_DAT;
      H_DAT: begin
        k_d  = k_q + 2'h1;
        st_d = (k_q + 2'h1 == n_q) ? H_IDLE : H_SEL;
      end
      default: st_d = H_IDLE;
    endcase
    ph_cnt_d = (ph_cnt_q == cdmu_pkg::PHI_HALF) ? 4'h0 : ph_cnt_q + 4'h1;
    phi_d    = (ph_cnt_q == cdmu_pkg::PHI_HALF) ? !phi_q : phi_q;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q     <= H_IDLE;
      n_q      <= 2'h0;
      k_q      <= 2'h0;
      mode_q   <= 8'h00;
      latch_q  <= 8'h00;
      vb_q     <= 1'b0;
      ph_cnt_q <= 4'h0;
      phi_q    <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        idx_q[i] <= 5'h00;
        val_q[i] <= 8'h00;
      end
    end else begin
      st_q     <= st_d;
      n_q      <= n_d;
      k_q      <= k_d;
      mode_q   <= mode_d;
      latch_q  <= latch_d;
      vb_q     <= vb_d;
      ph_cnt_q <= ph_cnt_d;
      phi_q    <= phi_d;
      idx_q    <= idx_d;
      val_q    <= val_d;
    end
  end

  // ------------------------------------------------------------------
  // Link drive and memory mux
  // ------------------------------------------------------------------
  assign lnk.bus_cs    = 1'b1;
  assign lnk.bus_rs    = st_q == H_DAT;
  assign lnk.bus_we    = st_q != H_IDLE;
  assign lnk.bus_wdata = (st_q == H_SEL) ? {3'h0, idx_q[k_q]} : val_q[k_q];
  assign lnk.phi2      = phi_q;

  // The mux follows the phase in interleave, else the request, within the cycle; only the priority scheme never holds the host off for the phase or blanking.
  always_comb begin
    case (scheme)
      cdmu_pkg::CDMU_INTERLEAVE: host_sel = phi_q;  // [R5]
      cdmu_pkg::CDMU_VBLANK:     host_sel = mem_req && vb_q;  // [R6]
      default:                   host_sel = mem_req;  // [R4]
    endcase
  end
  assign mem_grant  = !transp && !busy && mem_req && host_sel;  // [R2]
  assign vram_addr  = (!transp && host_sel) ? mem_addr : lnk.disp_addr;
  assign vram_wdata = transp ? latch_q : mem_wdata;
  assign vram_we    = transp ? lnk.raster_line[4] : mem_grant;
endmodule : cdmu_host

// ### bench/cdmu_checker.sv
// Concurrent checks on the link between the display device and its host.
`timescale 1ns/1ps
module cdmu_checker (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        bus_cs,
  input wire logic        bus_rs,
  input wire logic        bus_we,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata,
  input wire logic        phi2,
  input wire logic [13:0] disp_addr,
  input wire logic [4:0]  raster_line,
  input wire logic        disp_en,
  input wire logic        cursor,
  input wire logic        vsync
);
  // ----------------------------------------------------------------
  // Shadow state
  // ----------------------------------------------------------------
  logic [4:0] idx_q, idx_d;
  logic [7:0] mode_q, mode_d, ht_q, ht_d;
  logic       pend_q, pend_d, vsp_q, tr_il, blk, wr, rise;
  int         vs_q, vs_d, per_q, per_d, last_q, last_d, seen_q, seen_d;

  // Shadows follow bus writes; timing writes void the period history.
  always_comb begin
    wr = bus_cs && bus_we && bus_rs;
    rise = vsync && !vsp_q;
    idx_d = (bus_cs && bus_we && !bus_rs) ? bus_wdata[4:0] : idx_q;
    mode_d = (wr && idx_q == cdmu_pkg::REG_MODE) ? bus_wdata : mode_q;
    ht_d = (wr && idx_q == cdmu_pkg::REG_H_TOTAL) ? bus_wdata : ht_q;
    pend_d = (bus_cs && bus_rs && idx_q == cdmu_pkg::REG_DUMMY) || (pend_q && !raster_line[4]);
    vs_d = vsync ? vs_q + 1 : 0;
    per_d = rise ? 1 : per_q + 1;
    last_d = rise ? per_q : last_q;
    seen_d = (rise && seen_q < 3) ? seen_q + 1 : seen_q;
    if (wr && idx_q <= cdmu_pkg::REG_SCAN) seen_d = 0;
    tr_il = mode_q[3] && !mode_q[7];
    blk = mode_q[3] && mode_q[7];
  end

  // Registers only.
  always_ff @(posedge mclk) begin
    if (reset) begin
      idx_q <= 5'h00;
      mode_q <= 8'h00;
      ht_q <= cdmu_pkg::RST_H_TOTAL;
      pend_q <= 1'b0;
      vsp_q <= 1'b0;
      vs_q <= 0;
      per_q <= 0;
      last_q <= 0;
      seen_q <= 0;
    end else begin
      idx_q <= idx_d;
      mode_q <= mode_d;
      ht_q <= ht_d;
      pend_q <= pend_d;
      vsp_q <= vsync;
      vs_q <= vs_d;
      per_q <= per_d;
      last_q <= last_d;
      seen_q <= seen_d;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_quiet: assert property ($fell(reset) |-> bus_rdata == 8'h00 &&
    disp_addr == 14'h0000 && !vsync && !phi2 && !raster_line[4])
    else $error("outputs not quiet after reset");
  a_phi_high: assert property ($rose(phi2) |-> phi2[*4] ##1 !phi2)
    else $error("phase high length wrong");
  a_phi_low: assert property ($fell(phi2) |-> !phi2[*4] ##1 phi2)
    else $error("phase low length wrong");
  a_status_bits: assert property (bus_cs && !bus_we && !bus_rs |=> (bus_rdata & 8'h5f) == 8'h00)
    else $error("status has unused bits set");
  a_strobe_phase: assert property (tr_il && $past(tr_il) |-> raster_line[4] == $past(phi2))
    else $error("strobe not aligned to phase two");
  a_strobe_single: assert property (blk && raster_line[4] |=> !raster_line[4])
    else $error("blanking strobe longer than one cycle");
  a_strobe_pending: assert property (blk && $past(blk) && raster_line[4] |-> pend_q)
    else $error("strobe without pending update");
  a_vsync_width: assert property ($fell(vsync) |->
    vs_q == int'(cdmu_pkg::VSYNC_LINES) * (int'(ht_q) + 1))
    else $error("vsync width wrong");
  a_half_line: assert property (mode_q[1:0] == cdmu_pkg::IL_SYNC && rise && seen_q >= 2 |->
    (per_q - last_q == int'(ht_q) + 1) || (last_q - per_q == int'(ht_q) + 1))
    else $error("alternate fields not shifted by half a line");
endmodule : cdmu_checker

// ### bench/tb_top.sv
// Self-checking bench joining device and host ends.
`timescale 1ns/1ps
module tb_top;
  localparam int LIM = 20000;
  logic        mclk, reset, cfg_wr, mem_req, busy, mem_grant, vram_we, field_odd, ob;
  logic [4:0]  cfg_index;
  logic [7:0]  cfg_value, mem_wdata, vram_wdata, ud;
  logic [13:0] mem_addr, vram_addr, ua, ad;
  logic [6:0]  row_count;
  cdmu_pkg::cdmu_scheme_t scheme;
  int          mismatches, checks, ht, f, n, a, b, p1, p2, d0, d1, c0, c1;

  cdmu_if lnk ();
  cdmu_device cdmu_device_i (.mclk(mclk), .reset(reset), .lnk(lnk.device),
    .row_count(row_count), .field_odd(field_odd));
  cdmu_host cdmu_host_i (.mclk(mclk), .reset(reset), .lnk(lnk.host), .cfg_wr(cfg_wr),
    .cfg_index(cfg_index), .cfg_value(cfg_value), .scheme(scheme), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy), .mem_grant(mem_grant),
    .vram_addr(vram_addr), .vram_wdata(vram_wdata), .vram_we(vram_we));
  cdmu_checker cdmu_checker_i (.mclk(mclk), .reset(reset), .bus_cs(lnk.bus_cs),
    .bus_rs(lnk.bus_rs), .bus_we(lnk.bus_we), .bus_wdata(lnk.bus_wdata),
    .bus_rdata(lnk.bus_rdata), .phi2(lnk.phi2), .disp_addr(lnk.disp_addr),
    .raster_line(lnk.raster_line), .disp_en(lnk.disp_en), .cursor(lnk.cursor),
    .vsync(lnk.vsync));

  // 50 MHz clock.
  always #10 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Inputs change one nanosecond after the edge so sampling never races.
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic timeout(string what, int cnt);
    if (cnt >= LIM) begin
      check(what, 0, 1);
      test_done();
    end
  endtask : timeout

  function automatic logic sig(int s);
    case (s)
      0: return lnk.vsync;
      1: return lnk.disp_en;
      2: return lnk.cursor;
      default: return lnk.raster_line[4];
    endcase
  endfunction : sig

  function automatic int field(int h, int v, int s);
    return (h + 1) * (v + 1) * (s + 1);
  endfunction : field

  // Cycles until the chosen output next goes from low to high.
  task automatic rise(int s, output int cnt);
    for (cnt = 0; cnt < LIM && sig(s) !== 1'b0; cnt++) tick();
    for (; cnt < LIM && sig(s) !== 1'b1; cnt++) tick();
    timeout("rise wait", cnt);
  endtask : rise

  task automatic cfg(logic [4:0] idx, logic [7:0] val);
    int k;
    cfg_wr = 1'b1;
    cfg_index = idx;
    cfg_value = val;
    tick();
    cfg_wr = 1'b0;
    for (k = 0; k < LIM && busy !== 1'b0; k++) tick();
    timeout("host busy", k);
  endtask : cfg

  // Data is changed after the request so only a latched copy can match.
  task automatic upd(logic [13:0] addr, logic [7:0] dat);
    int k;
    mem_req = 1'b1;
    mem_addr = addr;
    mem_wdata = dat;
    tick();
    mem_req = 1'b0;
    mem_wdata = ~dat;
    for (k = 0; k < LIM && busy !== 1'b0; k++) tick();
    timeout("host busy", k);
  endtask : upd
  task automatic skew(logic [7:0] m, output int de, output int cu);
    int x;
    cfg(cdmu_pkg::REG_MODE, m);
    rise(0, x);
    rise(1, de);
    rise(0, x);
    rise(2, cu);
  endtask : skew

  // Counts strobes over a window and keeps the last strobe's view.
  task automatic window(int len, output int cnt);
    cnt = 0;
    for (int i = 0; i < len; i++) begin
      tick();
      if (lnk.raster_line[4] === 1'b1) begin
        cnt++;
        ad = lnk.disp_addr;
        ob = lnk.disp_en;
      end
    end
  endtask : window

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    cfg_wr = 1'b0;
    cfg_index = 5'h00;
    cfg_value = 8'h00;
    scheme = cdmu_pkg::CDMU_PRIO;
    mem_req = 1'b0;
    mem_addr = 14'h0000;
    mem_wdata = 8'h00;
    mismatches = 0;
    checks = 0;
    void'($urandom(37));
    repeat (8) @(posedge mclk);
    #1 reset = 1'b0;
    ht = 2 * ($urandom % 8) + 11;
    f = field(ht, 15, 7);
    cfg(cdmu_pkg::REG_H_TOTAL, ht[7:0]);
    rise(0, n);
    rise(0, n);
    check("field length", f, n);
    cfg(cdmu_pkg::REG_CURS_HI, 8'h00);
    cfg(cdmu_pkg::REG_CURS_LO, 8'h05);
    skew(8'h00, d0, c0);
    skew(8'h10, d1, n);
    check("enable skew", d0 + 1, d1);
    skew(8'h20, n, c1);
    check("cursor skew", c0 + 1, c1);
    ua = 14'($urandom);
    ud = 8'($urandom);
    mem_req = 1'b1;
    mem_addr = ua;
    mem_wdata = ud;
    #1;
    check("priority grant", 1, mem_grant);
    check("priority address", ua, vram_addr);
    check("priority data", ud, vram_wdata);
    scheme = cdmu_pkg::CDMU_INTERLEAVE;
    for (n = 0; n < 16; n++) begin
      tick();
      check("phase grant", lnk.phi2, mem_grant);
      check("phase address", lnk.phi2 ? mem_addr : lnk.disp_addr, vram_addr);
    end
    scheme = cdmu_pkg::CDMU_VBLANK;
    a = 0;
    b = 0;
    for (n = 0; n < f; n++) begin
      tick();
      a += (mem_grant === 1'b1);
      b += (mem_grant === 1'b1 && row_count > 7'h00 && row_count < 7'h0c);
    end
    check("blanking grants", 1, a > 0);
    check("grants while shown", 0, b);
    mem_req = 1'b0;
    cfg(cdmu_pkg::REG_MODE, 8'h08);
    ua = 14'($urandom);
    ud = 8'($urandom);
    upd(ua, ud);
    for (n = 0; n < 80 && !(lnk.raster_line[4] === 1'b1 && lnk.disp_addr === ua); n++) tick();
    check("update address", 1, n < 80);
    check("update data", ud, vram_wdata);
    check("update write", 1, vram_we);
    for (n = 0; n < 80 && !(lnk.raster_line[4] === 1'b1 && lnk.disp_addr === ua + 14'h1); n++)
      tick();
    check("pointer step", 1, n < 80);
    cfg(cdmu_pkg::REG_MODE, 8'h88);
    window(f, n);
    check("idle strobes", 0, n);
    ua = 14'($urandom);
    upd(ua, ud);
    window(f, n);
    check("blank strobes", 1, n);
    check("blank address", ua, ad);
    check("blank enable", 0, ob);
    for (n = 0; n < 20 && lnk.bus_rdata[7] !== 1'b1; n++) tick();
    check("update ready", 1, n < 20);
    cfg(cdmu_pkg::REG_MODE, 8'h01);
    cfg(cdmu_pkg::REG_H_TOTAL, 8'(ht - 1));
    rise(0, n);
    rise(0, p1);
    rise(0, p2);
    check("field pair", 2 * f, p1 + p2);
    check("half line", ht + 1, p1 > p2 ? p1 - p2 : p2 - p1);
    cfg(cdmu_pkg::REG_MODE, 8'h03);
    cfg(cdmu_pkg::REG_V_TOTAL, 8'h20);
    cfg(cdmu_pkg::REG_V_SYNC, 8'h1a);
    rise(0, n);
    rise(0, n);
    check("vsync row", 7'h0d, row_count);
    ob = field_odd;
    rise(0, n);
    check("field parity", !ob, field_odd);
    test_done();
  end
endmodule : tb_top
